// ---- common/alc_defs.svh ----
// Purpose: register indices, field positions, reset values, code limits
// Assumes: byte address is four times the register index
// Notes: definitions only
`ifndef ALC_DEFS_SVH
`define ALC_DEFS_SVH

`define ALC_IDX_STATUS1 8'h00
`define ALC_IDX_AIN_BASE 8'h04
`define ALC_IDX_MASK1 8'h0e
`define ALC_IDX_CFG1 8'h18
`define ALC_IDX_CFG3 8'h1a
`define ALC_IDX_OFS_INT 8'h21
`define ALC_IDX_OFS_EXT 8'h22
`define ALC_IDX_LIM_BASE 8'h30

`define ALC_AIN_CH 4
`define ALC_LIM_NUM 8

`define ALC_CFG1_MON_EN 0
`define ALC_CFG1_PIN_LO 1
`define ALC_CFG1_PIN_HI 2
`define ALC_CFG1_INT_POL 3
`define ALC_CFG3_RES10 1
`define ALC_CFG3_REF_VDD 4
`define ALC_CFG3_THA_EN 5
`define ALC_CFG3_THB_EN 6

`define ALC_PIN_EXT_SENSOR 2'h3

`define ALC_CFG1_RST 8'h08
`define ALC_CFG3_RST 8'h00
`define ALC_MASK1_RST 8'h00
`define ALC_OFS_RST 8'hd8
`define ALC_HLIM_RST 8'hff
`define ALC_LLIM_RST 8'h00

`define ALC_DAC8_MAX 10'h0ff
`define ALC_DAC10_MAX 10'h3ff

`endif

// ---- common/alc_pkg.sv ----
// Purpose: carrier types of the analog-input limit block
// Assumes: nothing
// Notes: constants live in alc_defs.svh
package alc_pkg;

    typedef struct packed {
        logic wr;
        logic [7:0] idx;
    } alc_bus_req_type;

    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [9:0] value;
    } alc_ain_sample_type;

    typedef struct packed {
        logic valid;
        logic ext;
        logic [9:0] quarter;
    } alc_temp_sample_type;

endpackage : alc_pkg

// ---- core/alc_therm_code.sv ----
// Purpose: temperature to thermal DAC code, one per DAC
// Assumes: temperature in signed quarter degrees
// Notes: below the zero-volt point the code rests at zero
`timescale 1ns/10ps
`include "alc_defs.svh"
module alc_therm_code (
    input wire logic hclk, // clock
    input wire logic hresetn, // async reset, active low
    input wire logic load, // take a new temperature
    input wire logic res10, // 10-bit mode when high
    input wire logic [9:0] temp_q, // signed quarter degrees
    input wire logic [7:0] offset, // zero-volt temperature code
    output logic [9:0] code_r // DAC code
);
    wire signed [11:0] zero_q = $signed({{2{offset[7]}}, offset, 2'b00});
    wire signed [11:0] temp_s = $signed({{2{temp_q[9]}}, temp_q});
    wire signed [11:0] diff_q = temp_s - zero_q;
    wire signed [11:0] step = res10 ? diff_q : (diff_q >>> 2);
    wire [9:0] full = res10 ? `ALC_DAC10_MAX : `ALC_DAC8_MAX;
    wire over = step[10:0] > {1'b0, full};
    wire [9:0] code_nxt = step[11] ? 10'h000 : (over ? full : step[9:0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_r <= 10'h000;
        end else if (load) begin
            code_r <= code_nxt;
        end
    end
endmodule : alc_therm_code

// ---- core/alc_top.sv ----
// Purpose: analog-input limit compare, thermal DAC codes, AHB-Lite regs
// Assumes: single-word AHB-Lite transfers, converter samples on ports
// Notes: zero wait states, always OKAY
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "alc_defs.svh"
module alc_top (
    input wire logic hclk, // bus clock, 100 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [9:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic [31:0] hrdata, // read data
    input wire alc_pkg::alc_ain_sample_type ain_sample, // converter result
    input wire alc_pkg::alc_temp_sample_type temp_sample, // temperature
    output logic conv_enable, // converter may run
    output logic adc_ref_vdd, // reference from supply when high
    output logic [1:0] shared_pin_function, // shared pin use
    output logic therm_a_sel, // DAC A follows internal temperature
    output logic therm_b_sel, // DAC B follows external temperature
    output logic [9:0] dac_a_code, // thermal code for DAC A
    output logic [9:0] dac_b_code, // thermal code for DAC B
    output logic dac_a_upd, // one-cycle update strobe, DAC A
    output logic dac_b_upd, // one-cycle update strobe, DAC B
    output logic irq // interrupt output
);
    alc_pkg::alc_bus_req_type req_r;
    logic [7:0] status1_r;
    logic [7:0] mask1_r;
    logic [7:0] cfg1_r;
    logic [7:0] cfg3_r;
    logic [7:0] ofs_int_r;
    logic [7:0] ofs_ext_r;
    logic [7:0] lim_r [0:`ALC_LIM_NUM-1];
    logic [9:0] ain_r [0:`ALC_AIN_CH-1];
    logic [31:0] hrdata_r;
    logic irq_r;
    logic dac_a_upd_r;
    logic dac_b_upd_r;

    // address phase
    wire accept = hsel & htrans[1] & hready;
    wire [7:0] addr_idx = haddr[9:2];
    wire rd_accept = accept & ~hwrite;
    wire [7:0] wr_byte = hwdata[7:0];
    wire rd_status = rd_accept & (addr_idx == `ALC_IDX_STATUS1);

    // data phase writes
    wire wr_mask1 = req_r.wr & (req_r.idx == `ALC_IDX_MASK1);
    wire wr_cfg1 = req_r.wr & (req_r.idx == `ALC_IDX_CFG1);
    wire wr_cfg3 = req_r.wr & (req_r.idx == `ALC_IDX_CFG3);
    wire wr_ofs_int = req_r.wr & (req_r.idx == `ALC_IDX_OFS_INT);
    wire wr_ofs_ext = req_r.wr & (req_r.idx == `ALC_IDX_OFS_EXT);
    wire wr_lim = req_r.wr & (req_r.idx[7:3] == 5'(`ALC_IDX_LIM_BASE >> 3));

    // next values let a read right after a write see the new byte
    wire [7:0] mask1_nxt = wr_mask1 ? wr_byte : mask1_r;
    wire [7:0] cfg1_nxt = wr_cfg1 ? wr_byte : cfg1_r;
    wire [7:0] cfg3_nxt = wr_cfg3 ? wr_byte : cfg3_r;
    wire [7:0] ofs_int_nxt = wr_ofs_int ? wr_byte : ofs_int_r;
    wire [7:0] ofs_ext_nxt = wr_ofs_ext ? wr_byte : ofs_ext_r;
    logic [7:0] lim_nxt [0:`ALC_LIM_NUM-1];

    // configuration outputs
    // gate conversions
    assign conv_enable = cfg1_r[`ALC_CFG1_MON_EN];
    assign adc_ref_vdd = cfg3_r[`ALC_CFG3_REF_VDD];
    assign shared_pin_function = cfg1_r[`ALC_CFG1_PIN_HI:`ALC_CFG1_PIN_LO];
    wire ext_sensor = shared_pin_function == `ALC_PIN_EXT_SENSOR;
    assign therm_a_sel = cfg3_r[`ALC_CFG3_THA_EN];
    assign therm_b_sel = cfg3_r[`ALC_CFG3_THB_EN] & ext_sensor;
    wire res10 = cfg3_r[`ALC_CFG3_RES10];
    wire int_pol = cfg1_r[`ALC_CFG1_INT_POL];

    // analog sample intake
    // pins 1,2 idle as sensor
    wire chan_blocked = ext_sensor & ~ain_sample.chan[1];
    wire ain_take = ain_sample.valid & conv_enable & ~chan_blocked;
    wire [7:0] ain_top = ain_sample.value[9:2];

    logic [7:0] set_vec;
    genvar g;
    generate
        for (g = 0; g < `ALC_AIN_CH; g = g + 1) begin : g_chan
            wire hit = ain_take & (ain_sample.chan == 2'(g));
            wire [7:0] hlim = lim_r[2*g];
            wire [7:0] llim = lim_r[2*g+1];
            wire hi_viol = ain_top > hlim;
            wire lo_viol = ain_top <= llim;
            assign set_vec[2*g] = hit & hi_viol & ~mask1_r[2*g];
            assign set_vec[2*g+1] = hit & lo_viol & ~mask1_r[2*g+1];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ain_r[g] <= 10'h000;
                end else if (hit) begin
                    ain_r[g] <= ain_sample.value;
                end
            end
        end
        for (g = 0; g < `ALC_LIM_NUM; g = g + 1) begin : g_lim
            wire sel = wr_lim & (req_r.idx[2:0] == 3'(g));
            assign lim_nxt[g] = sel ? wr_byte : lim_r[g];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    lim_r[g] <= (g % 2 == 1) ? `ALC_LLIM_RST : `ALC_HLIM_RST;
                end else begin
                    lim_r[g] <= lim_nxt[g];
                end
            end
        end
    endgenerate

    // sticky status, a new event wins over the clear-on-read
    // flag capture
    wire [7:0] status1_nxt = (status1_r & ~{8{rd_status}}) | set_vec;
    wire pending = |(status1_r & ~mask1_r);
    wire irq_nxt = int_pol ? pending : ~pending;

    // thermal DAC codes
    wire temp_ok = temp_sample.valid & conv_enable;
    wire load_a = temp_ok & ~temp_sample.ext & therm_a_sel;
    wire load_b = temp_ok & temp_sample.ext & therm_b_sel;

    alc_therm_code u_therm_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(load_a),
        .res10(res10),
        .temp_q(temp_sample.quarter),
        .offset(ofs_int_r),
        .code_r(dac_a_code)
    );

    alc_therm_code u_therm_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(load_b),
        .res10(res10),
        .temp_q(temp_sample.quarter),
        .offset(ofs_ext_r),
        .code_r(dac_b_code)
    );

    // read selection
    wire is_ain = addr_idx[7:2] == 6'(`ALC_IDX_AIN_BASE >> 2);
    wire is_lim = addr_idx[7:3] == 5'(`ALC_IDX_LIM_BASE >> 3);
    wire [9:0] rd_val =
        (addr_idx == `ALC_IDX_STATUS1) ? {2'b00, status1_r} :
        (addr_idx == `ALC_IDX_MASK1) ? {2'b00, mask1_nxt} :
        (addr_idx == `ALC_IDX_CFG1) ? {2'b00, cfg1_nxt} :
        (addr_idx == `ALC_IDX_CFG3) ? {2'b00, cfg3_nxt} :
        (addr_idx == `ALC_IDX_OFS_INT) ? {2'b00, ofs_int_nxt} :
        (addr_idx == `ALC_IDX_OFS_EXT) ? {2'b00, ofs_ext_nxt} :
        is_ain ? ain_r[addr_idx[1:0]] :
        is_lim ? {2'b00, lim_nxt[addr_idx[2:0]]} :
        10'h000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else begin
            req_r.wr <= accept & hwrite;
            req_r.idx <= addr_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_accept) begin
            hrdata_r <= {22'h00_0000, rd_val};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask1_r <= `ALC_MASK1_RST;
            cfg1_r <= `ALC_CFG1_RST;
            cfg3_r <= `ALC_CFG3_RST;
            ofs_int_r <= `ALC_OFS_RST;
            ofs_ext_r <= `ALC_OFS_RST;
        end else begin
            mask1_r <= mask1_nxt;
            cfg1_r <= cfg1_nxt;
            cfg3_r <= cfg3_nxt;
            ofs_int_r <= ofs_int_nxt;
            ofs_ext_r <= ofs_ext_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status1_r <= 8'h00;
            irq_r <= 1'b0;
            dac_a_upd_r <= 1'b0;
            dac_b_upd_r <= 1'b0;
        end else begin
            status1_r <= status1_nxt;
            irq_r <= irq_nxt;
            dac_a_upd_r <= load_a;
            dac_b_upd_r <= load_b;
        end
    end

    // zero wait states keep the slave simple; no error response exists
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign irq = irq_r;
    assign dac_a_upd = dac_a_upd_r;
    assign dac_b_upd = dac_b_upd_r;
endmodule : alc_top

// ---- dv/alc_top_sva.sv ----
// Purpose: port checker for alc_top
// Assumes: sees only top ports, one clock
// Notes: bound at the foot of this file
`timescale 1ns/10ps
module alc_top_chk (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire alc_pkg::alc_temp_sample_type temp_sample, // temperature
    input wire logic conv_enable, // monitor enable
    input wire logic [1:0] shared_pin_function, // pin use
    input wire logic therm_a_sel, // dac a enable
    input wire logic therm_b_sel, // dac b enable
    input wire logic [9:0] dac_a_code, // dac a code
    input wire logic [9:0] dac_b_code, // dac b code
    input wire logic dac_a_upd, // dac a strobe
    input wire logic dac_b_upd // dac b strobe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_upd_a_cause: assert property (dac_a_upd |->
        $past(temp_sample.valid && !temp_sample.ext)) else $error("a strobe");
    a_upd_b_cause: assert property (dac_b_upd |->
        $past(temp_sample.valid && temp_sample.ext)) else $error("b strobe");
    a_upd_a_sel: assert property (dac_a_upd |->
        $past(therm_a_sel)) else $error("a not enabled");
    a_upd_b_pins: assert property (dac_b_upd |->
        $past(shared_pin_function) == 2'h3) else $error("b pins");
    a_bsel_pins: assert property (therm_b_sel |->
        shared_pin_function == 2'h3) else $error("b select pins");
    a_code_a_hold: assert property (!dac_a_upd |->
        $stable(dac_a_code)) else $error("a code moved");
    a_code_b_hold: assert property (!dac_b_upd |->
        $stable(dac_b_code)) else $error("b code moved");
    a_conv_gate: assert property ((dac_a_upd || dac_b_upd) |->
        $past(conv_enable)) else $error("update while off");
endmodule : alc_top_chk
bind alc_top alc_top_chk alc_top_chk_inst (.hclk, .hresetn, .temp_sample,
    .conv_enable, .shared_pin_function, .therm_a_sel, .therm_b_sel,
    .dac_a_code, .dac_b_code, .dac_a_upd, .dac_b_upd);

// ---- dv/tb.sv ----
// Purpose: self-checking bench for alc_top
// Assumes: zero-wait AHB-Lite slave, mask bit high means masked
// Notes: random mix of configs, samples and limits, seeded
`timescale 1ns/10ps
module tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [9:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [31:0] hwdata = '0, hrdata, rv;
    logic hreadyout, hresp, conv_enable, adc_ref_vdd, therm_a_sel;
    logic therm_b_sel, dac_a_upd, dac_b_upd, irq;
    logic [1:0] shared_pin_function;
    logic [9:0] dac_a_code, dac_b_code;
    alc_pkg::alc_ain_sample_type smp = '0;
    alc_pkg::alc_temp_sample_type tmp = '0;
    int err_count = 0, total_checks = 0, seed = 43211;
    localparam logic [7:0] RI [8] = '{8'h00, 8'h18, 8'h1a, 8'h0e, 8'h21,
        8'h30, 8'h31, 8'h3f};
    localparam logic [7:0] RE [8] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'hd8,
        8'hff, 8'h00, 8'h00};
    alc_top alc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .ain_sample(smp), .temp_sample(tmp), .conv_enable,
        .adc_ref_vdd, .shared_pin_function, .therm_a_sel, .therm_b_sel,
        .dac_a_code, .dac_b_code, .dac_a_upd, .dac_b_upd, .irq);
    initial forever #5 hclk = ~hclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic edge_wait;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            err_count++;
            conclude;
        end
    endtask : edge_wait
    task automatic bus(input logic w, input logic [7:0] i,
        input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {i, 2'h0};
        edge_wait;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        edge_wait;
        rv = hrdata;
    endtask : bus
    function automatic logic [7:0] st_exp(input logic [1:0] c,
        input logic [9:0] v, input logic [7:0] hi, lo, m);
        logic [7:0] s;
        s = 8'h0;
        s[2*c] = v[9:2] > hi;
        s[2*c+1] = v[9:2] <= lo;
        return s & ~m;
    endfunction : st_exp
    function automatic logic [9:0] dac_exp(input logic signed [9:0] q,
        input int z, input logic r10);
        int d;
        int top;
        top = r10 ? 1023 : 255;
        d = r10 ? int'(q) - 4 * z : (int'(q) - 4 * z) >>> 2;
        if (d < 0) d = 0;
        if (d > top) d = top;
        return d[9:0];
    endfunction : dac_exp
    // two's complement offset code, per the zero-volt coding
    function automatic logic [7:0] ofs_code(input int z);
        return z < 0 ? 8'h80 | 8'(z + 128) : 8'(z);
    endfunction : ofs_code
    initial begin
        logic [7:0] hi, lo, m, f1, f3, st;
        logic [9:0] v, q, la, lb;
        logic [9:0] lv [4];
        logic [1:0] c;
        logic ext, tk;
        int z;
        la = 0;
        lb = 0;
        lv = '{default: 10'h0};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(conv_enable, 0);
        foreach (RI[k]) begin
            bus(1'b0, RI[k], 8'h0);
            chk(rv, {24'h0, RE[k]});
            chk(hresp, 1'b0);
        end
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            c = 2'($random(seed));
            v = 10'($random(seed));
            hi = 8'($random(seed));
            lo = 8'($random(seed));
            m = 8'($random(seed));
            f1 = {4'h0, 3'($random(seed)), 1'(i % 5 != 0)};
            f3 = 8'($random(seed)) & 8'h72;
            ext = 1'($random(seed));
            q = 10'($random(seed));
            z = $random(seed) % 128;
            if (i < 3) begin
                hi = 8'h80;
                lo = 8'h80;
                v = {8'h7f + 8'(i), 2'h3};
                m = ~(8'h03 << (2 * c));
            end
            if (i == 3) begin
                z = -128;
                q = 10'h1ff;
            end
            bus(1'b1, 8'h18, f1);
            bus(1'b1, 8'h1a, f3);
            bus(1'b1, 8'h0e, m);
            bus(1'b1, 8'h30 + 8'(2 * c), hi);
            bus(1'b1, 8'h31 + 8'(2 * c), lo);
            bus(1'b1, ext ? 8'h22 : 8'h21, ofs_code(z));
            tk = f1[0] && !(f1[2:1] == 2'h3 && c < 2);
            smp <= '{1'b1, c, v};
            @(posedge hclk);
            smp.valid <= 1'b0;
            st = tk ? st_exp(c, v, hi, lo, m) : 8'h0;
            if (tk) lv[c] = v;
            // irq launched one edge after the flag, read one edge later
            repeat (2) @(posedge hclk);
            chk(irq, f1[3] ? |st : !(|st));
            chk(conv_enable, f1[0]);
            chk(shared_pin_function, f1[2:1]);
            chk(adc_ref_vdd, f3[4]);
            chk(therm_a_sel, f3[5]);
            chk(therm_b_sel, f3[6] && f1[2:1] == 2'h3);
            bus(1'b0, 8'h00, 8'h0);
            chk(rv, st);
            bus(1'b0, 8'h00, 8'h0);
            chk(rv, 0);
            chk(irq, !f1[3]);
            bus(1'b0, 8'h04 + 8'(c), 8'h0);
            chk(rv, lv[c]);
            tk = f1[0] && (ext ? f3[6] && f1[2:1] == 2'h3 : f3[5]);
            tmp <= '{1'b1, ext, q};
            @(posedge hclk);
            tmp.valid <= 1'b0;
            if (tk && ext) lb = dac_exp(q, z, f3[1]);
            if (tk && !ext) la = dac_exp(q, z, f3[1]);
            // strobe and code launched at the load edge, settled here
            @(posedge hclk);
            chk(ext ? dac_b_upd : dac_a_upd, tk);
            chk(ext ? dac_b_code : dac_a_code, ext ? lb : la);
        end
        $display("random test done");
        conclude;
    end
endmodule : tb
